/* rtl/mbw_pkg.sv */
// Purpose: Shared constants for the multiple-register write handler
// Assumes: Byte stream already framed by an upstream character receiver
// Notes: Frame offsets are byte positions counted from the slave address
package mbw_pkg;
	localparam logic [7:0] FUNC_WRITE_MULTI = 8'h10;
	localparam logic [7:0] BROADCAST_ADDR = 8'h00;
	localparam logic [15:0] MAX_REGS = 16'h0010;
	localparam int WORDS = 16;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	localparam logic [15:0] CRC_RESIDUE = 16'h0000;
	// Byte positions within the query
	localparam logic [7:0] POS_ADDR = 8'h00;
	localparam logic [7:0] POS_FUNC = 8'h01;
	localparam logic [7:0] POS_START_HI = 8'h02;
	localparam logic [7:0] POS_START_LO = 8'h03;
	localparam logic [7:0] POS_CNT_HI = 8'h04;
	localparam logic [7:0] POS_CNT_LO = 8'h05;
	localparam logic [7:0] POS_BYTES = 8'h06;
	localparam logic [7:0] POS_DATA = 8'h07;
	// Header plus two check bytes, data excluded
	localparam logic [7:0] FRAME_OVERHEAD = 8'h09;
	localparam logic [7:0] IDX_MAX = 8'hFF;
	// Positions of the reply check bytes, the last one being its final byte
	localparam logic [2:0] REPLY_CRC_LO = 3'h6;
	localparam logic [2:0] REPLY_LAST = 3'h7;
	// Exception codes reported beside the frame
	localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
	localparam logic [7:0] EXC_WRITE_REJECT = 8'h04;
	typedef enum logic [2:0] {
		ST_RX = 3'b000,
		ST_ISSUE = 3'b001,
		ST_CHECK = 3'b010,
		ST_REPLY = 3'b011
	} state_t;
endpackage

/* rtl/mbw_crc_byte.sv */
// Purpose: One byte step of the reflected CRC-16 used on the serial link
// Assumes: Purely combinational, caller holds the running value
// Notes: Bits are folded in least significant first
`timescale 1ns/1ps
module mbw_crc_byte
(
	// Running value and new byte
	input wire logic [15:0] i_crc,
	input wire logic [7:0] i_byte,
	// Updated value
	output logic [15:0] o_crc
);
	// Eight shift steps, one per data bit
	always_comb
	begin
		logic [15:0] c;
		c = i_crc ^ {8'h00, i_byte};
		for (int b = 0; b < 8; b++)
		begin
			if (c[0])
				c = (c >> 1) ^ mbw_pkg::CRC_POLY;
			else
				c = c >> 1;
		end
		o_crc = c;
	end
endmodule

/* rtl/mbw_write_multi.sv */
// Purpose: Slave handling of the write-multiple-registers query
// Assumes: i_frame_end pulses once per silence gap after the last byte
// Notes: Values are buffered until the check passes, then committed
`timescale 1ns/1ps

// Notes on behaviour
// - Function 10h writes consecutive holding registers
// - At most sixteen registers per query
// - Commit values in ascending address order
// - Rejected value stops; earlier writes stay committed
// - Address, function, start address high first
// - Register count follows, high byte first
// - Byte count equals twice register count
// - One word per register, high byte first
// - Frames end with CRC, low byte first
// - Reply echoes address, function, start, count
// - Sixteen-bit registers, even address holds upper half
module mbw_write_multi
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Station address
	input wire logic [7:0] i_slave_addr,
	// Received bytes
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	input wire logic i_frame_end,
	// Reply bytes
	output logic o_tx_valid,
	output logic [7:0] o_tx_data,
	input wire logic i_tx_ready,
	// Register write port
	output logic o_wr_en,
	output logic [15:0] o_wr_addr,
	output logic [15:0] o_wr_data,
	input wire logic i_wr_ok,
	// Status
	output logic o_busy,
	output logic o_exc,
	output logic [7:0] o_exc_code
);
	mbw_pkg::state_t state_q, state_d;
	logic [7:0] idx_q, idx_d;
	logic [15:0] crc_q, crc_d;
	logic [15:0] crc_rx_next;
	logic [7:0] addr_q, addr_d;
	logic [7:0] func_q, func_d;
	logic [15:0] start_q, start_d;
	logic [15:0] cnt_q, cnt_d;
	logic [7:0] nbytes_q, nbytes_d;
	logic [4:0] word_q, word_d;
	logic [2:0] tx_idx_q, tx_idx_d;
	logic [15:0] tx_crc_q, tx_crc_d;
	logic [15:0] tx_crc_next;
	logic tx_valid_q, tx_valid_d;
	logic [7:0] tx_data_q, tx_data_d;
	logic wr_en_q, wr_en_d;
	logic [15:0] wr_addr_q, wr_addr_d;
	logic [15:0] wr_data_q, wr_data_d;
	logic exc_q, exc_d;
	logic [7:0] exc_code_q, exc_code_d;
	logic busy_q, busy_d;
	logic [15:0] words [mbw_pkg::WORDS];
	logic [7:0] data_off;
	logic buf_we;
	logic frame_ok, for_us, params_ok;

	// Running check over received bytes
	mbw_crc_byte u_crc_rx
	(
		.i_crc(crc_q),
		.i_byte(i_rx_data),
		.o_crc(crc_rx_next)
	);

	// Running check over reply bytes
	mbw_crc_byte u_crc_tx
	(
		.i_crc(tx_crc_q),
		.i_byte(tx_data_q),
		.o_crc(tx_crc_next)
	);

	// Reply byte at a position, check bytes taken from the given value
	function automatic logic [7:0] reply_byte(input logic [2:0] pos,
		input logic [7:0] a, input logic [15:0] s, input logic [15:0] n,
		input logic [15:0] c);
		case (pos)
			3'h0: reply_byte = a;
			3'h1: reply_byte = mbw_pkg::FUNC_WRITE_MULTI;
			3'h2: reply_byte = s[15:8];
			3'h3: reply_byte = s[7:0];
			3'h4: reply_byte = n[15:8];
			3'h5: reply_byte = n[7:0];
			3'h6: reply_byte = c[7:0];
			default: reply_byte = c[15:8];
		endcase
	endfunction

	// Frame checks, evaluated at the silence gap
	always_comb
	begin
		// Whole-frame residue is zero when the check bytes match
		frame_ok = (crc_q == mbw_pkg::CRC_RESIDUE)
			&& (idx_q == nbytes_q + mbw_pkg::FRAME_OVERHEAD);
		for_us = (addr_q == i_slave_addr)
			|| (addr_q == mbw_pkg::BROADCAST_ADDR);
		params_ok = (cnt_q != 16'h0000) && (cnt_q <= mbw_pkg::MAX_REGS)
			&& ({8'h00, nbytes_q} == {cnt_q[14:0], 1'b0});
		data_off = idx_q - mbw_pkg::POS_DATA;
		buf_we = (state_q == mbw_pkg::ST_RX) && i_rx_valid
			&& (idx_q >= mbw_pkg::POS_DATA) && (data_off < 8'h20);
	end

	// Data word buffer, high byte at even offset
	always_ff @(posedge i_sys_clk)
	begin
		if (buf_we)
		begin
			if (data_off[0])
				words[data_off[4:1]][7:0] <= i_rx_data;
			else
				words[data_off[4:1]][15:8] <= i_rx_data;
		end
	end

	// Next-state logic for reception, commit and reply
	always_comb
	begin
		state_d = state_q;
		idx_d = idx_q;
		crc_d = crc_q;
		addr_d = addr_q;
		func_d = func_q;
		start_d = start_q;
		cnt_d = cnt_q;
		nbytes_d = nbytes_q;
		word_d = word_q;
		tx_idx_d = tx_idx_q;
		tx_crc_d = tx_crc_q;
		tx_valid_d = tx_valid_q;
		tx_data_d = tx_data_q;
		wr_en_d = 1'b0;
		wr_addr_d = wr_addr_q;
		wr_data_d = wr_data_q;
		exc_d = 1'b0;
		exc_code_d = exc_code_q;
		case (state_q)
			mbw_pkg::ST_RX:
			begin
				if (i_frame_end)
				begin
					// Fresh frame starts after every gap
					idx_d = 8'h00;
					crc_d = mbw_pkg::CRC_INIT;
					if (frame_ok && for_us
						&& func_q == mbw_pkg::FUNC_WRITE_MULTI)
					begin
						if (params_ok)
						begin
							word_d = 5'h00;
							state_d = mbw_pkg::ST_ISSUE;
						end
						else
						begin
							exc_d = 1'b1;
							exc_code_d = mbw_pkg::EXC_ILLEGAL_VALUE;
						end
					end
				end
				else if (i_rx_valid)
				begin
					crc_d = crc_rx_next;
					if (idx_q != mbw_pkg::IDX_MAX)
						idx_d = idx_q + 8'h01;
					// Header fields, high byte first
					case (idx_q)
						mbw_pkg::POS_ADDR: addr_d = i_rx_data;
						mbw_pkg::POS_FUNC: func_d = i_rx_data;
						mbw_pkg::POS_START_HI: start_d[15:8] = i_rx_data;
						mbw_pkg::POS_START_LO: start_d[7:0] = i_rx_data;
						mbw_pkg::POS_CNT_HI: cnt_d[15:8] = i_rx_data;
						mbw_pkg::POS_CNT_LO: cnt_d[7:0] = i_rx_data;
						mbw_pkg::POS_BYTES: nbytes_d = i_rx_data;
						default: ;
					endcase
				end
			end
			mbw_pkg::ST_ISSUE:
			begin
				// One word per pass, lowest address first
				wr_en_d = 1'b1;
				wr_addr_d = start_q + {11'h000, word_q};
				wr_data_d = words[word_q[3:0]];
				word_d = word_q + 5'h01;
				state_d = mbw_pkg::ST_CHECK;
			end
			mbw_pkg::ST_CHECK:
			begin
				if (!i_wr_ok)
				begin
					// Stop here; earlier words are left as written
					exc_d = 1'b1;
					exc_code_d = mbw_pkg::EXC_WRITE_REJECT;
					state_d = mbw_pkg::ST_RX;
				end
				else if ({11'h000, word_q} != cnt_q)
					state_d = mbw_pkg::ST_ISSUE;
				else if (addr_q == mbw_pkg::BROADCAST_ADDR)
					state_d = mbw_pkg::ST_RX; // Broadcasts get no reply
				else
				begin
					tx_idx_d = 3'h0;
					tx_crc_d = mbw_pkg::CRC_INIT;
					tx_valid_d = 1'b1;
					tx_data_d = addr_q;
					state_d = mbw_pkg::ST_REPLY;
				end
			end
			mbw_pkg::ST_REPLY:
			begin
				if (tx_valid_q && i_tx_ready)
				begin
					// Check bytes are not folded into the check itself
					if (tx_idx_q < mbw_pkg::REPLY_CRC_LO)
						tx_crc_d = tx_crc_next;
					if (tx_idx_q == mbw_pkg::REPLY_LAST)
					begin
						tx_valid_d = 1'b0;
						state_d = mbw_pkg::ST_RX;
					end
					else
					begin
						tx_idx_d = tx_idx_q + 3'h1;
						tx_data_d = reply_byte(tx_idx_d, addr_q, start_q,
							cnt_q, tx_crc_d);
					end
				end
			end
			default:
				state_d = mbw_pkg::ST_RX;
		endcase
		// Busy kept in a flop so the port has no decode glitches
		busy_d = (state_d != mbw_pkg::ST_RX);
	end

	// State registers
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			state_q <= mbw_pkg::ST_RX;
			idx_q <= 8'h00;
			crc_q <= mbw_pkg::CRC_INIT;
			addr_q <= 8'h00;
			func_q <= 8'h00;
			start_q <= 16'h0000;
			cnt_q <= 16'h0000;
			nbytes_q <= 8'h00;
			word_q <= 5'h00;
			tx_idx_q <= 3'h0;
			tx_crc_q <= mbw_pkg::CRC_INIT;
			tx_valid_q <= 1'b0;
			tx_data_q <= 8'h00;
			wr_en_q <= 1'b0;
			wr_addr_q <= 16'h0000;
			wr_data_q <= 16'h0000;
			exc_q <= 1'b0;
			exc_code_q <= 8'h00;
			busy_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			idx_q <= idx_d;
			crc_q <= crc_d;
			addr_q <= addr_d;
			func_q <= func_d;
			start_q <= start_d;
			cnt_q <= cnt_d;
			nbytes_q <= nbytes_d;
			word_q <= word_d;
			tx_idx_q <= tx_idx_d;
			tx_crc_q <= tx_crc_d;
			tx_valid_q <= tx_valid_d;
			tx_data_q <= tx_data_d;
			wr_en_q <= wr_en_d;
			wr_addr_q <= wr_addr_d;
			wr_data_q <= wr_data_d;
			exc_q <= exc_d;
			exc_code_q <= exc_code_d;
			busy_q <= busy_d;
		end
	end

	// Outputs straight from flops
	always_comb
	begin
		o_tx_valid = tx_valid_q;
		o_tx_data = tx_data_q;
		o_wr_en = wr_en_q;
		o_wr_addr = wr_addr_q;
		o_wr_data = wr_data_q;
		o_exc = exc_q;
		o_exc_code = exc_code_q;
		o_busy = busy_q;
	end
endmodule

/* tb/mbw_write_multi_assertions.sv */
// Purpose: Port checks for the write-multiple handler
// Assumes: One clock, synchronous reset
// Notes: Bound from the test top
`timescale 1ns/1ps
module mbw_write_multi_checker
(
	// Clock, reset and inputs
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_frame_end,
	input wire logic i_tx_ready,
	input wire logic i_wr_ok,
	// Design outputs
	input wire logic o_tx_valid,
	input wire logic [7:0] o_tx_data,
	input wire logic o_wr_en,
	input wire logic [15:0] o_wr_addr,
	input wire logic o_busy,
	input wire logic o_exc,
	input wire logic [7:0] o_exc_code
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	// Write slots and refusals
	sequence s_two_wr;
		o_wr_en ##2 o_wr_en;
	endsequence
	sequence s_refused;
		o_wr_en && !i_wr_ok;
	endsequence
	property p_wr_step;
		s_two_wr |-> o_wr_addr == $past(o_wr_addr, 2) + 16'h0001;
	endproperty
	a_wr_step: assert property (p_wr_step) else $error("addr step");
	property p_wr_busy;
		o_wr_en |-> o_busy;
	endproperty
	a_wr_busy: assert property (p_wr_busy) else $error("idle write");
	property p_wr_pulse;
		o_wr_en |=> !o_wr_en;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("long pulse");
	property p_refuse;
		s_refused |=> o_exc && o_exc_code == 8'h04;
	endproperty
	a_refuse: assert property (p_refuse) else $error("no exception");
	// A refusal ends the query: no write, no reply
	property p_refuse_stop;
		s_refused |=> (!o_wr_en && !o_tx_valid) [*8];
	endproperty
	a_refuse_stop: assert property (p_refuse_stop) else $error("went on");
	property p_tx_hold;
		o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("byte lost");
	property p_end_quiet;
		i_frame_end && !o_busy |=> !o_wr_en && !o_tx_valid;
	endproperty
	a_end_quiet: assert property (p_end_quiet) else $error("too early");
	property p_exc_code;
		o_exc |-> o_exc_code == 8'h03 || o_exc_code == 8'h04;
	endproperty
	a_exc_code: assert property (p_exc_code) else $error("bad code");
endmodule

/* tb/mbw_master_model.sv */
// Purpose: Register store and reply sink on the far side
// Assumes: Writes are answered in the same cycle
// Notes: REJ_VALUE stands for an out-of-range datum
`timescale 1ns/1ps
module mbw_master_model
#(
	parameter logic [15:0] REJ_VALUE = 16'hBAD0
)
(
	// Clock
	input wire logic i_sys_clk,
	// Register write port
	input wire logic i_wr_en,
	input wire logic [15:0] i_wr_addr,
	input wire logic [15:0] i_wr_data,
	output logic o_wr_ok,
	// Reply stream
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	input wire logic i_slow,
	output logic o_tx_ready
);
	logic [31:0] wr_log[$];
	logic [7:0] rx_q[$];
	// Only the marked value is out of range
	assign o_wr_ok = i_wr_data !== REJ_VALUE;
	// Slow mode stalls every other cycle to stretch the reply
	initial o_tx_ready = 1'b1;
	always @(negedge i_sys_clk)
		o_tx_ready <= i_slow ? !o_tx_ready : 1'b1;
	// Keep accepted writes and taken reply bytes
	always @(posedge i_sys_clk)
	begin
		if (i_wr_en && o_wr_ok)
			wr_log.push_back({i_wr_addr, i_wr_data});
		if (i_tx_valid && o_tx_ready)
			rx_q.push_back(i_tx_data);
	end
endmodule

/* tb/mbw_write_multi_test.sv */
// Purpose: Self-checking bench of the write-multiple handler
// Assumes: Station address 04h
// Notes: Bytes of a frame are sent back to back, then the bench waits on busy
`timescale 1ns/1ps
module mbw_write_multi_test;
	typedef logic [7:0] bytes_t[$];
	logic i_sys_clk, i_rst, i_rx_valid, i_frame_end, slow;
	logic [7:0] i_rx_data, o_tx_data, o_exc_code, exc_last;
	logic o_tx_valid, tx_ready, o_wr_en, wr_ok, o_busy, o_exc;
	logic [15:0] o_wr_addr, o_wr_data;
	int failures, checks_done;
	mbw_write_multi i_mbw_write_multi (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_slave_addr(8'h04), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
		.i_frame_end(i_frame_end), .o_tx_valid(o_tx_valid),
		.o_tx_data(o_tx_data), .i_tx_ready(tx_ready), .o_wr_en(o_wr_en),
		.o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .i_wr_ok(wr_ok),
		.o_busy(o_busy), .o_exc(o_exc), .o_exc_code(o_exc_code));
	mbw_master_model i_mbw_master_model (.i_sys_clk(i_sys_clk),
		.i_wr_en(o_wr_en), .i_wr_addr(o_wr_addr), .i_wr_data(o_wr_data),
		.o_wr_ok(wr_ok), .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data),
		.i_slow(slow), .o_tx_ready(tx_ready));
	// 10 MHz clock
	initial
	begin
		i_sys_clk = 1'b0;
		forever #50 i_sys_clk = ~i_sys_clk;
	end
	// Exception pulses last one cycle, so latch the code
	always @(posedge i_sys_clk)
		if (o_exc === 1'b1)
			exc_last <= o_exc_code;
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task test_done;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	function automatic bytes_t add_crc(input bytes_t q);
		logic [15:0] c;
		c = mbw_pkg::CRC_INIT;
		foreach (q[i])
		begin
			c ^= {8'h00, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ mbw_pkg::CRC_POLY : c >> 1;
		end
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		return q;
	endfunction
	// Send one frame, close it, wait a bounded time for idle
	task send(input bytes_t q);
		int n;
		n = 0;
		i_mbw_master_model.wr_log.delete();
		i_mbw_master_model.rx_q.delete();
		exc_last = 8'h00;
		foreach (q[i])
		begin
			@(negedge i_sys_clk);
			i_rx_valid = 1'b1;
			i_rx_data = q[i];
		end
		@(negedge i_sys_clk);
		i_rx_valid = 1'b0;
		i_frame_end = 1'b1;
		@(negedge i_sys_clk);
		i_frame_end = 1'b0;
		repeat (2) @(negedge i_sys_clk);
		while (o_busy !== 1'b0)
		begin
			@(negedge i_sys_clk);
			n++;
			if (n > 400)
			begin
				chk("busy timeout", 0, 1);
				test_done();
			end
		end
		repeat (2) @(negedge i_sys_clk);
	endtask
	task chk_wr(input logic [15:0] start, input logic [15:0] v[$]);
		chk("write count", v.size(), i_mbw_master_model.wr_log.size());
		foreach (v[i])
			chk("write", {start + 16'(i), v[i]}, i_mbw_master_model.wr_log[i]);
	endtask
	task chk_rx(input bytes_t e);
		chk("reply length", e.size(), i_mbw_master_model.rx_q.size());
		foreach (e[i])
			chk("reply byte", e[i], i_mbw_master_model.rx_q[i]);
	endtask
	task chk_none;
		chk("write count", 0, i_mbw_master_model.wr_log.size());
		chk("reply length", 0, i_mbw_master_model.rx_q.size());
	endtask
	task t_example(input logic s);
		slow = s;
		send({8'h04, 8'h10, 8'h06, 8'h00, 8'h00, 8'h06, 8'h0C, 8'h00, 8'h00,
			8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h32, 8'h00, 8'h00, 8'h00,
			8'h96, 8'h85, 8'h70});
		chk_wr(16'h0600, {16'h0000, 16'h0002, 16'h0000, 16'h0032, 16'h0000,
			16'h0096});
		chk_rx({8'h04, 8'h10, 8'h06, 8'h00, 8'h00, 8'h06, 8'h40,
			8'hD6});
	endtask
	task t_bad_crc;
		bytes_t q;
		q = add_crc({8'h04, 8'h10, 8'h00, 8'h20, 8'h00, 8'h01, 8'h02, 8'h12,
			8'h34});
		q[10] = q[10] ^ 8'h01;
		send(q);
		chk_none();
	endtask
	task t_counts;
		bytes_t q;
		logic [15:0] v[$];
		q = {8'h04, 8'h10, 8'h01, 8'h00, 8'h00, 8'h10, 8'h20};
		for (int k = 0; k < 32; k++)
			q.push_back(8'(k));
		for (int w = 0; w < 16; w++)
			v.push_back({8'(2 * w), 8'(2 * w + 1)});
		send(add_crc(q));
		chk_wr(16'h0100, v);
		chk("reply length", 8, i_mbw_master_model.rx_q.size());
		send(add_crc({8'h04, 8'h10, 8'h01, 8'h00, 8'h00, 8'h11, 8'h02, 8'h12,
			8'h34}));
		chk_none();
		chk("exception code", 8'h03, exc_last);
		send(add_crc({8'h04, 8'h10, 8'h01, 8'h00, 8'h00, 8'h02, 8'h03, 8'h12,
			8'h34, 8'h56}));
		chk_none();
		chk("exception code", 8'h03, exc_last);
	endtask
	// Even start and count keep both halves together; third word refused
	task t_reject;
		send(add_crc({8'h04, 8'h10, 8'h00, 8'h40, 8'h00, 8'h04, 8'h08, 8'h11,
			8'h11, 8'h22, 8'h22, 8'hBA, 8'hD0, 8'h33, 8'h33}));
		chk_wr(16'h0040, {16'h1111, 16'h2222});
		chk("exception code", 8'h04, exc_last);
		chk("reply length", 0, i_mbw_master_model.rx_q.size());
	endtask
	// Other station, other function, then a broadcast that writes silently
	task t_other;
		send(add_crc({8'h05, 8'h10, 8'h00, 8'h10, 8'h00, 8'h01, 8'h02, 8'hAB,
			8'hCD}));
		chk_none();
		chk("exception code", 8'h00, exc_last);
		send(add_crc({8'h04, 8'h0F, 8'h00, 8'h10, 8'h00, 8'h01, 8'h02, 8'hAB,
			8'hCD}));
		chk_none();
		chk("exception code", 8'h00, exc_last);
		send(add_crc({8'h00, 8'h10, 8'h00, 8'h30, 8'h00, 8'h02, 8'h04, 8'h12,
			8'h34, 8'h56, 8'h78}));
		chk_wr(16'h0030, {16'h1234, 16'h5678});
		chk("reply length", 0, i_mbw_master_model.rx_q.size());
	endtask
	initial
	begin
		i_rst = 1'b1;
		i_rx_valid = 1'b0;
		i_rx_data = 8'h00;
		i_frame_end = 1'b0;
		slow = 1'b0;
		exc_last = 8'h00;
		failures = 0;
		checks_done = 0;
		repeat (5) @(negedge i_sys_clk);
		i_rst = 1'b0;
		t_example(1'b0);
		t_example(1'b1);
		t_bad_crc();
		t_counts();
		t_reject();
		t_other();
		test_done();
	end
endmodule
bind mbw_write_multi mbw_write_multi_checker i_mbw_write_multi_checker (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_frame_end(i_frame_end),
	.i_tx_ready(i_tx_ready), .i_wr_ok(i_wr_ok), .o_tx_valid(o_tx_valid),
	.o_tx_data(o_tx_data), .o_wr_en(o_wr_en), .o_wr_addr(o_wr_addr),
	.o_busy(o_busy), .o_exc(o_exc), .o_exc_code(o_exc_code));
